// file: src/ilc_pkg.sv
// Package: constants for the interlace count and transpose logic
package ilc_pkg;
  // ***********************
  // Register map
  // ***********************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT_TALLY = 12'h008;
  localparam logic [11:0] ADDR_SWAP_TALLY = 12'h00c;
  // Control fields
  localparam int CTRL_SYNC_ENABLE_BIT = 0;
  localparam int CTRL_SOFT_CLEAR_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Status fields
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_SELECT_BIT = 1;
  localparam int STAT_SET_BUSY_BIT = 2;
  // ***********************
  // Timing
  // ***********************
  localparam int CLK_PERIOD_NS = 50;
  // Width of the reshaped count and transpose pulses
  localparam int SHAPED_PULSE_NS = 500;
  localparam int SHAPED_PULSE_CYCLES =
    (SHAPED_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Set-pointer pulse lies between 0.5 and 1 us
  localparam int SET_PULSE_MIN_NS = 500;
  localparam int SET_PULSE_MAX_NS = 1000;
  localparam int SET_PULSE_MIN_CYCLES =
    (SET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SET_PULSE_MAX_CYCLES = SET_PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int SET_PULSE_CYCLES = SET_PULSE_MIN_CYCLES;
  localparam int PULSE_CNT_W = 6;
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_RESET = 6'h00;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [31:0] TALLY_RESET = 32'h0000_0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// file: src/ilc_core.sv
// Interlace count and transpose logic with APB register access
// What this block does
// - With interlace selected, make count and transpose pulses internally.
// - Reshape each fill or drain sync into a pulse of fixed width.
// - Master clear with interlace deselected replicates as pointer clear.
// - With interlace selected, pointer clear stays inactive always.
// - Master clear with interlace selected gives one 0.5-1 us set pulse.
// - Count pulse for each sync repeating the previous command.
// - Count when fill meets flag fill, or drain meets flag drain.
// - Fill sync sets the fill/drain flag; drain sync clears it.
// - Drain after fill produces no count pulse.
// - Interlace deselected keeps internal count generation idle.
// - External count pulse is merged onto the count output.
// - Transpose pulse for each sync changing the previous command.
// - Transpose gating uses the flag value held before this sync.
// - Transpose pulse timing comes from the triggering sync.
// - Drain with flag fill gives transpose and clears the flag.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
module ilc_core #(
  parameter int SHAPED_CYCLES = ilc_pkg::SHAPED_PULSE_CYCLES,
  parameter int SET_CYCLES = ilc_pkg::SET_PULSE_CYCLES
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the external system
  input wire logic interlace_select,
  input wire logic fill_sync,
  input wire logic drain_sync,
  input wire logic master_clear,
  input wire logic ext_count,
  // Pulses to the pointer, count network and swap register
  output logic count_pulse,
  output logic transpose_pulse,
  output logic clear_pointer,
  output logic set_pointer_clear_swap
);

  // Elaboration check on pulse lengths
  if (SHAPED_CYCLES < 1 || SHAPED_CYCLES >= (1 << ilc_pkg::PULSE_CNT_W) ||
      SET_CYCLES < ilc_pkg::SET_PULSE_MIN_CYCLES ||
      SET_CYCLES > ilc_pkg::SET_PULSE_MAX_CYCLES) begin : g_bad_len
    $error("ilc_core: pulse length parameters out of range");
  end

  localparam logic [ilc_pkg::PULSE_CNT_W-1:0] SHAPED_LEN =
    ilc_pkg::PULSE_CNT_W'(SHAPED_CYCLES);
  localparam logic [ilc_pkg::PULSE_CNT_W-1:0] SET_LEN =
    ilc_pkg::PULSE_CNT_W'(SET_CYCLES);
  localparam int NPIN = 5;

  // ***********************
  // Pin synchronisers
  // ***********************
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync_a;
  logic [NPIN-1:0] sync_b;
  logic [NPIN-1:0] sync_c;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_lvl_d;

  assign pin_raw = {ext_count, master_clear, drain_sync, fill_sync,
                    interlace_select};

  // Three-stage capture of each pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Level changes once the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_lvl[gi] <= 1'b0;
          pin_lvl_d[gi] <= 1'b0;
        end else begin
          if (sync_b[gi] == sync_c[gi]) begin
            pin_lvl[gi] <= sync_c[gi];
          end
          pin_lvl_d[gi] <= pin_lvl[gi];
        end
      end
    end
  endgenerate

  logic sel;
  logic fill_ev;
  logic drain_ev;
  logic mc_lvl;
  logic mc_ev;
  logic ext_ev;
  logic sync_enable;
  logic soft_clear;

  assign sel = pin_lvl[0];
  // Rising edges reshape each sync regardless of its width
  assign fill_ev = pin_lvl[1] & ~pin_lvl_d[1] & sync_enable;
  assign drain_ev = pin_lvl[2] & ~pin_lvl_d[2] & sync_enable &
                    ~fill_ev;
  assign mc_lvl = pin_lvl[3];
  assign mc_ev = (pin_lvl[3] & ~pin_lvl_d[3]) | soft_clear;
  assign ext_ev = pin_lvl[4] & ~pin_lvl_d[4];

  // ***********************
  // Fill/drain flag and gating
  // ***********************
  logic flag;
  logic count_trig;
  logic swap_trig;

  // Fill sets, drain clears, at the sync itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= ilc_pkg::FLAG_RESET;
    end else if (fill_ev) begin
      flag <= 1'b1;
    end else if (drain_ev) begin
      flag <= 1'b0;
    end
  end

  // Same command as before gives a count
  assign count_trig = sel & ((fill_ev & flag) |
                             (drain_ev & ~flag));
  // Changed command gives a transpose, using the old flag
  assign swap_trig = sel & ((fill_ev & ~flag) |
                            (drain_ev & flag));

  // ***********************
  // Pulse shapers
  // ***********************
  logic [ilc_pkg::PULSE_CNT_W-1:0] count_cnt;
  logic [ilc_pkg::PULSE_CNT_W-1:0] swap_cnt;
  logic [ilc_pkg::PULSE_CNT_W-1:0] set_cnt;

  // Count pulse, internal or external source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_cnt <= ilc_pkg::PULSE_CNT_RESET;
      count_pulse <= 1'b0;
    end else if (count_trig || ext_ev) begin
      count_cnt <= SHAPED_LEN - 1'b1;
      count_pulse <= 1'b1;
    end else if (count_cnt != '0) begin
      count_cnt <= count_cnt - 1'b1;
    end else begin
      count_pulse <= 1'b0;
    end
  end

  // Transpose pulse starts on the sync edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_cnt <= ilc_pkg::PULSE_CNT_RESET;
      transpose_pulse <= 1'b0;
    end else if (swap_trig) begin
      swap_cnt <= SHAPED_LEN - 1'b1;
      transpose_pulse <= 1'b1;
    end else if (swap_cnt != '0) begin
      swap_cnt <= swap_cnt - 1'b1;
    end else begin
      transpose_pulse <= 1'b0;
    end
  end

  // Single set pulse on master clear in interlace mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_cnt <= ilc_pkg::PULSE_CNT_RESET;
      set_pointer_clear_swap <= 1'b0;
    end else if (mc_ev && sel && !set_pointer_clear_swap) begin
      set_cnt <= SET_LEN - 1'b1;
      set_pointer_clear_swap <= 1'b1;
    end else if (set_cnt != '0) begin
      set_cnt <= set_cnt - 1'b1;
    end else begin
      set_pointer_clear_swap <= 1'b0;
    end
  end

  // Pointer clear follows master clear while deselected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_pointer <= 1'b0;
    end else begin
      clear_pointer <= (mc_lvl | soft_clear) & ~sel;
    end
  end

  // ***********************
  // APB registers
  // ***********************
  logic [31:0] count_tally;
  logic [31:0] swap_tally;
  logic wr_ok;
  logic rd_ok;
  logic mapped;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == ilc_pkg::ADDR_CTRL) ||
                (a == ilc_pkg::ADDR_STATUS) ||
                (a == ilc_pkg::ADDR_COUNT_TALLY) ||
                (a == ilc_pkg::ADDR_SWAP_TALLY);
  endfunction

  // Status word assembled from its field positions
  function automatic logic [31:0] status_word(input logic fl,
                                              input logic sl,
                                              input logic busy);
    status_word = 32'h0000_0000;
    status_word[ilc_pkg::STAT_FLAG_BIT] = fl;
    status_word[ilc_pkg::STAT_SELECT_BIT] = sl;
    status_word[ilc_pkg::STAT_SET_BUSY_BIT] = busy;
  endfunction

  // Control word as read back; soft clear always reads 0
  function automatic logic [31:0] ctrl_word(input logic en);
    ctrl_word = 32'h0000_0000;
    ctrl_word[ilc_pkg::CTRL_SYNC_ENABLE_BIT] = en;
  endfunction

  assign mapped = is_mapped(paddr);
  assign wr_ok = psel & penable & pwrite & mapped;
  assign rd_ok = psel & penable & ~pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Control register, soft clear is a self-clearing strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_enable <= ilc_pkg::CTRL_RESET[ilc_pkg::CTRL_SYNC_ENABLE_BIT];
      soft_clear <= 1'b0;
    end else if (wr_ok && paddr == ilc_pkg::ADDR_CTRL) begin
      sync_enable <= pwdata[ilc_pkg::CTRL_SYNC_ENABLE_BIT];
      soft_clear <= pwdata[ilc_pkg::CTRL_SOFT_CLEAR_BIT];
    end else begin
      soft_clear <= 1'b0;
    end
  end

  // Tallies of issued pulses, cleared by writing their address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_tally <= ilc_pkg::TALLY_RESET;
    end else if (count_trig || ext_ev) begin
      count_tally <= count_tally + 32'h0000_0001;
    end else if (wr_ok && paddr == ilc_pkg::ADDR_COUNT_TALLY) begin
      count_tally <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_tally <= ilc_pkg::TALLY_RESET;
    end else if (swap_trig) begin
      swap_tally <= swap_tally + 32'h0000_0001;
    end else if (wr_ok && paddr == ilc_pkg::ADDR_SWAP_TALLY) begin
      swap_tally <= 32'h0000_0000;
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ilc_pkg::RDATA_RESET;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ilc_pkg::ADDR_CTRL: begin
          prdata <= ctrl_word(sync_enable);
        end
        ilc_pkg::ADDR_STATUS: begin
          prdata <= status_word(flag, sel, set_pointer_clear_swap);
        end
        ilc_pkg::ADDR_COUNT_TALLY: begin
          prdata <= count_tally;
        end
        ilc_pkg::ADDR_SWAP_TALLY: begin
          prdata <= swap_tally;
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule

// file: verif/ilc_core_monitor.sv
// Checker of the interlace count and transpose pins
`timescale 1ns/10ps
module ilc_core_monitor #(
  parameter int SHAPED_CYCLES = 10,
  parameter int SET_CYCLES = 10
) (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  // Pins
  input wire logic interlace_select,
  input wire logic fill_sync,
  input wire logic drain_sync,
  input wire logic master_clear,
  input wire logic ext_count,
  input wire logic count_pulse,
  input wire logic transpose_pulse,
  input wire logic clear_pointer,
  input wire logic set_pointer_clear_swap
);
  int cnt_len, trn_len, set_len;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Lengths of the high phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_len <= 0;
      trn_len <= 0;
      set_len <= 0;
    end else begin
      cnt_len <= count_pulse ? cnt_len + 1 : 0;
      trn_len <= transpose_pulse ? trn_len + 1 : 0;
      set_len <= set_pointer_clear_swap ? set_len + 1 : 0;
    end
  end
  sequence s_clear_desel;
    (master_clear && !interlace_select)[*7];
  endsequence
  sequence s_sync_before;
    $past(fill_sync, 5) || $past(drain_sync, 5);
  endsequence
  AST_CLR_COPY: assert property (s_clear_desel |-> clear_pointer)
    else $error("pointer clear missing");
  AST_CLR_HELD: assert property (interlace_select[*6] |-> !clear_pointer)
    else $error("pointer clear while selected");
  AST_SET_LEN: assert property ($fell(set_pointer_clear_swap) |->
    set_len == SET_CYCLES && set_len >= 10 && set_len <= 20)
    else $error("set pulse width wrong");
  AST_SET_SEL: assert property ($rose(set_pointer_clear_swap) |->
    interlace_select) else $error("set pulse without select");
  AST_CNT_LEN: assert property ($fell(count_pulse) |->
    cnt_len == SHAPED_CYCLES) else $error("count width wrong");
  AST_TRN_LEN: assert property ($fell(transpose_pulse) |->
    trn_len == SHAPED_CYCLES) else $error("transpose width wrong");
  AST_CNT_IDLE: assert property ((!interlace_select && !ext_count)[*8]
    |-> !$rose(count_pulse)) else $error("count while deselected");
  AST_TRN_IDLE: assert property (!interlace_select[*8]
    |-> !$rose(transpose_pulse)) else $error("transpose deselected");
  AST_TRN_TIME: assert property ($rose(transpose_pulse) |->
    s_sync_before) else $error("transpose not timed by sync");
  AST_UNMAPPED: assert property (psel && penable && paddr > 12'h00c
    |-> pslverr) else $error("no error on unmapped access");
endmodule
bind ilc_core ilc_core_monitor #(.SHAPED_CYCLES(SHAPED_CYCLES),
  .SET_CYCLES(SET_CYCLES)) ilc_core_monitor_inst (.pclk, .presetn, .psel,
  .penable, .paddr, .pslverr, .interlace_select, .fill_sync, .drain_sync,
  .master_clear, .ext_count, .count_pulse, .transpose_pulse,
  .clear_pointer, .set_pointer_clear_swap);

// file: verif/ilc_sys_model.sv
// Model of the external system issuing syncs and clears
`timescale 1ns/10ps
module ilc_sys_model (
  // Clock and one-cycle request from the bench
  input wire logic pclk,
  input wire logic [3:0] req,
  // Pins toward the block
  output logic fill_sync,
  output logic drain_sync,
  output logic master_clear,
  output logic ext_count
);
  logic [3:0] held = 4'h0;
  int left = 0;
  // One pulse of seven cycles per request, one sync per cycle
  always @(posedge pclk) begin
    if (req != 4'h0) begin
      held <= req;
      left <= 6;
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      held <= 4'h0;
    end
  end
  assign {ext_count, master_clear, drain_sync, fill_sync} = held;
endmodule

// file: verif/ilc_core_tb.sv
// Self-checking bench of the interlace count and transpose logic
`timescale 1ns/10ps
module ilc_core_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, interlace_select = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] req = 4'h0, was = 4'h0;
  logic pready, pslverr, fill_sync, drain_sync, master_clear, ext_count;
  logic count_pulse, transpose_pulse, clear_pointer, set_pointer_clear_swap;
  int num_errors = 0, samples_checked = 0, seed = 32'h59c0e1c8;
  int flag = 0, e_cnt = 0, e_trn = 0, n_cnt = 0, n_trn = 0;
  int n_set = 0, n_clr = 0;
  always #25 pclk = ~pclk;
  ilc_core ilc_core_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .interlace_select,
    .fill_sync, .drain_sync, .master_clear, .ext_count, .count_pulse,
    .transpose_pulse, .clear_pointer, .set_pointer_clear_swap);
  ilc_sys_model ilc_sys_model_inst (.pclk, .req, .fill_sync, .drain_sync,
    .master_clear, .ext_count);
  // Rising edges of the output pulses
  always @(posedge pclk) begin
    was <= {count_pulse, transpose_pulse, set_pointer_clear_swap,
      clear_pointer};
    if (count_pulse && !was[3]) n_cnt++;
    if (transpose_pulse && !was[2]) n_trn++;
    if (set_pointer_clear_swap && !was[1]) n_set++;
    if (clear_pointer && !was[0]) n_clr++;
  end
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(string s, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %0h, seen %0h", s, e, g);
      num_errors++;
    end
  endtask
  // APB transfer, held until pready is sampled high
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d = 32'h0);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : $random(seed);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb wait states", 0, n);
  endtask
  task automatic send(logic [3:0] c);
    @(posedge pclk);
    req <= c;
    @(posedge pclk);
    req <= 4'h0;
    repeat (30) @(posedge pclk);
  endtask
  // Reference: repeat counts, change transposes, flag tracks command
  task automatic sync(int f);
    if (interlace_select && f == flag) e_cnt++;
    if (interlace_select && f != flag) e_trn++;
    flag = f;
    send(f ? 4'h1 : 4'h2);
    check("count pulses", e_cnt, n_cnt);
    check("transpose pulses", e_trn, n_trn);
    apb(1'b0, ilc_pkg::ADDR_STATUS);
    check("flag", flag, rd[ilc_pkg::STAT_FLAG_BIT]);
  endtask
  initial begin
    #(20000 * 50);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ilc_pkg::ADDR_CTRL);
    check("ctrl", ilc_pkg::CTRL_RESET, rd);
    apb(1'b0, 12'h010);
    check("slverr", 1, err);
    check("bad rdata", 0, rd);
    interlace_select <= 1'b1;
    repeat (8) @(posedge pclk);
    sync(0);
    sync(1);
    sync(1);
    sync(0);
    repeat (12) sync($random(seed) & 1);
    // Syncs are ignored while disabled: no pulse, flag kept
    apb(1'b1, ilc_pkg::ADDR_CTRL, 32'h0000_0000);
    send(flag ? 4'h2 : 4'h1);
    apb(1'b1, ilc_pkg::ADDR_CTRL, 32'h0000_0001);
    check("disabled count", e_cnt, n_cnt);
    check("disabled transpose", e_trn, n_trn);
    apb(1'b0, ilc_pkg::ADDR_STATUS);
    check("disabled flag", flag, rd[ilc_pkg::STAT_FLAG_BIT]);
    send(4'h4);
    check("set pulses", 1, n_set);
    check("pointer clears", 0, n_clr);
    interlace_select <= 1'b0;
    repeat (8) @(posedge pclk);
    repeat (6) sync($random(seed) & 1);
    send(4'h4);
    check("pointer clears", 1, n_clr);
    check("set pulses", 1, n_set);
    // Soft clear acts as a master clear while deselected
    apb(1'b1, ilc_pkg::ADDR_CTRL, 32'h0000_0003);
    repeat (4) @(posedge pclk);
    check("soft pointer clears", 2, n_clr);
    check("soft set pulses", 1, n_set);
    e_cnt++;
    send(4'h8);
    check("merged count", e_cnt, n_cnt);
    apb(1'b0, ilc_pkg::ADDR_COUNT_TALLY);
    check("count tally", e_cnt, rd);
    apb(1'b0, ilc_pkg::ADDR_SWAP_TALLY);
    check("swap tally", e_trn, rd);
    apb(1'b1, ilc_pkg::ADDR_COUNT_TALLY);
    apb(1'b0, ilc_pkg::ADDR_COUNT_TALLY);
    check("tally cleared", 0, rd);
    give_verdict();
  end
endmodule
